// file: rtl/afc_params.svh
`ifndef AFC_PARAMS_SVH
`define AFC_PARAMS_SVH
// ----------------------------------------
// register decode
// ----------------------------------------
`define AFC_ADDR 3'h2
`define AFC_LCR_SEL 3'h4
`define AFC_RESET 8'h00
// ----------------------------------------
// field positions
// ----------------------------------------
`define AFC_BIT_IR 1
`define AFC_BIT_HD 2
`define AFC_BIT_LG 3
`define AFC_BIT_RL 4
`define AFC_DLY_LO 5
`define AFC_DLY_HI 7
// ----------------------------------------
// timing
// ----------------------------------------
`define AFC_SIR_MAX_BPS 115200
`endif

// file: rtl/afc_pkg.sv
package afc_pkg;
    typedef struct packed {
        logic [2:0] hold_delay;
        logic receive_listen_enable;
        logic large_block_tx_interrupt;
        logic half_duplex_bus_enable;
        logic infrared_mode_enable;
        logic reserved0;
    } afc_type;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_SEND = 2'b01,
        ST_HOLD = 2'b10
    } drv_state_type;
endpackage

// file: rtl/afc_hold_counter.sv
module afc_hold_counter
    import afc_pkg::*;
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic nrst,
    // control
    input wire logic clear,
    input wire logic load,
    input wire logic [2:0] length,
    input wire logic bit_tick,
    // status
    output logic expired
);
    logic [2:0] count_reg;
    logic [2:0] count_next;
    logic expired_reg;
    logic expired_next;
    always_comb begin
        count_next = count_reg;
        expired_next = 1'b0;
        if (clear) begin
            count_next = 3'h0;
        end else if (load) begin
            count_next = length;
            expired_next = (length == 3'h0);
        end else if (bit_tick && count_reg != 3'h0) begin
            count_next = count_reg - 3'h1;
            expired_next = (count_reg == 3'h1);
        end
    end
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            count_reg <= 3'h0;
            expired_reg <= 1'b0;
        end else begin
            count_reg <= count_next;
            expired_reg <= expired_next;
        end
    end
    assign expired = expired_reg;
endmodule

// file: rtl/afc_ctrl.sv
// How it works
// R1: infrared enable bit puts the UART in SIR mode, meant for up to 115.2 kbit/s
// R2: in half-duplex mode driver enable is high while transmit FIFO or shifter holds data
// R3: driver enable stays high until hold delay expires, then goes low
// R4: half-duplex without large-block holds transmit interrupts until shifter is empty
// R5: large-block with half-duplex gives normal threshold or empty transmit interrupts
// R6: receive-listen bit only affects the receiver in half-duplex or infrared mode; it gates the timeout interrupt in every mode
// R7: listen plus half-duplex stores all received characters, own echo included
// R8: half-duplex off means receiver enabled for normal full-duplex use; infrared with listen off still disables it while transmitting
// R9: half-duplex on and listen off disables receiver while transmitting
// R10: infrared with listen off drops the optical echo of transmit data
// R11: listen bit clear suppresses character timeout interrupt; thresholds stay
// R12: three-bit field sets hold time in bit times, half-duplex mode only
// R13: hold delay starts only when shifter and transmit FIFO are both empty
// R14: write to transmit holding register during hold cancels it, enable stays high
// R15: register sits at address 010 when upper line-control bits are 100; bit 0 reserved
// R16: half-duplex off restores modem-control output and clears the hold counter
`include "afc_params.svh"
module afc_ctrl
    import afc_pkg::*;
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic nrst,
    // register bus
    input wire logic cs_n,
    input wire logic [2:0] addr,
    input wire logic wr_strobe,
    input wire logic rd_strobe,
    input wire logic [7:0] wdata,
    input wire logic [2:0] lcr_upper,
    input wire logic thr_write,
    output logic [7:0] rdata,
    output logic rdata_valid,
    // transmitter state
    input wire logic tx_fifo_empty,
    input wire logic tsr_empty,
    input wire logic tx_below_threshold,
    input wire logic bit_tick,
    input wire logic tx_active,
    // interrupt sources
    input wire logic tx_int_normal,
    input wire logic timeout_int_raw,
    output logic tx_int,
    output logic timeout_int_en,
    // receiver and mode
    input wire logic mcr_dtr,
    output logic rx_enable,
    output logic sir_mode,
    output logic dtr_out
);
    // ----------------------------------------
    // register
    // ----------------------------------------
    afc_type afc_reg;
    afc_type afc_next;
    logic [7:0] rdata_reg;
    logic [7:0] rdata_next;
    logic rvalid_reg;
    logic rvalid_next;
    function automatic logic afc_hit(input logic [2:0] a, input logic [2:0] line_control_register);
        afc_hit = (a == `AFC_ADDR) && (line_control_register == `AFC_LCR_SEL);
    endfunction
    always_comb begin
        afc_next = afc_reg;
        rdata_next = rdata_reg;
        rvalid_next = 1'b0;
        if (!cs_n && wr_strobe && afc_hit(addr, lcr_upper)) begin // R15
            afc_next = afc_type'(wdata);
            afc_next.reserved0 = 1'b0; // R15
        end
        if (!cs_n && rd_strobe && afc_hit(addr, lcr_upper)) begin // R15
            rdata_next = 8'(afc_reg);
            rvalid_next = 1'b1;
        end
    end
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            afc_reg <= afc_type'(`AFC_RESET);
            rdata_reg <= 8'h00;
            rvalid_reg <= 1'b0;
        end else begin
            afc_reg <= afc_next;
            rdata_reg <= rdata_next;
            rvalid_reg <= rvalid_next;
        end
    end
    // ----------------------------------------
    // driver enable sequencer
    // ----------------------------------------
    drv_state_type state_reg;
    drv_state_type state_next;
    logic hd;
    logic tx_pending;
    logic hold_load;
    logic hold_clear;
    logic hold_done;
    assign hd = afc_reg.half_duplex_bus_enable;
    assign tx_pending = !tx_fifo_empty || !tsr_empty;
    always_comb begin
        state_next = state_reg;
        hold_load = 1'b0;
        hold_clear = 1'b0;
        if (!hd) begin
            state_next = ST_IDLE;
            hold_clear = 1'b1; // R16
        end else begin
            case (state_reg)
                ST_IDLE: begin
                    if (tx_pending || thr_write) begin
                        state_next = ST_SEND; // R2
                    end
                end
                ST_SEND: begin
                    if (!tx_pending && !thr_write) begin
                        state_next = ST_HOLD; // R13
                        hold_load = 1'b1; // R12
                    end
                end
                ST_HOLD: begin
                    if (thr_write || tx_pending) begin
                        state_next = ST_SEND; // R14
                        hold_clear = 1'b1; // R14
                    end else if (hold_done) begin
                        state_next = ST_IDLE; // R3
                    end
                end
                default: begin
                    state_next = ST_IDLE;
                end
            endcase
        end
    end
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            state_reg <= ST_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end
    afc_hold_counter u_hold (
        .ref_clk(ref_clk),
        .nrst(nrst),
        .clear(hold_clear),
        .load(hold_load),
        .length(afc_reg.hold_delay),
        .bit_tick(bit_tick),
        .expired(hold_done)
    );
    // ----------------------------------------
    // outputs
    // ----------------------------------------
    logic dtr_reg;
    logic dtr_next;
    logic rxen_reg;
    logic rxen_next;
    logic sir_reg;
    logic sir_next;
    logic txint_reg;
    logic txint_next;
    logic toen_reg;
    logic toen_next;
    logic tsr_empty_d_reg;
    logic tsr_empty_d_next;
    always_comb begin
        tsr_empty_d_next = tsr_empty;
        sir_next = afc_reg.infrared_mode_enable; // R1
        if (hd) begin
            dtr_next = (state_next != ST_IDLE); // R2 R3
        end else begin
            dtr_next = mcr_dtr; // R16
        end
        if (!hd) begin
            rxen_next = 1'b1; // R8
        end else if (afc_reg.receive_listen_enable) begin
            rxen_next = 1'b1; // R6 R7
        end else begin
            rxen_next = !tx_active; // R9
        end
        if (afc_reg.infrared_mode_enable && !afc_reg.receive_listen_enable && tx_active) begin
            rxen_next = 1'b0; // R10
        end
        if (hd && !afc_reg.large_block_tx_interrupt) begin
            txint_next = tsr_empty && !tsr_empty_d_reg; // R4
        end else begin
            txint_next = tx_int_normal; // R5
        end
        toen_next = afc_reg.receive_listen_enable && timeout_int_raw; // R11
    end
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            dtr_reg <= 1'b0;
            rxen_reg <= 1'b1;
            sir_reg <= 1'b0;
            txint_reg <= 1'b0;
            toen_reg <= 1'b0;
            tsr_empty_d_reg <= 1'b1;
        end else begin
            dtr_reg <= dtr_next;
            rxen_reg <= rxen_next;
            sir_reg <= sir_next;
            txint_reg <= txint_next;
            toen_reg <= toen_next;
            tsr_empty_d_reg <= tsr_empty_d_next;
        end
    end
    assign rdata = rdata_reg;
    assign rdata_valid = rvalid_reg;
    assign dtr_out = dtr_reg;
    assign rx_enable = rxen_reg;
    assign sir_mode = sir_reg;
    assign tx_int = txint_reg;
    assign timeout_int_en = toen_reg;
endmodule

// file: sim/afc_xcvr_model.sv
module afc_xcvr_model (
    // driver side
    input wire logic dtr_out,
    input wire logic tx_line,
    // bus side
    output logic bus_line
);
    timeunit 1ns;
    timeprecision 1ps;
    // biased bus idles high when no node drives it
    assign bus_line = dtr_out ? tx_line : 1'b1;
endmodule

// file: sim/afc_ctrl_sva.sv
module afc_ctrl_sva
    import afc_pkg::*;
(
    input wire logic ref_clk, nrst, cs_n, wr_strobe, rd_strobe, thr_write,
    input wire logic [2:0] addr, lcr_upper,
    input wire logic [7:0] wdata, rdata,
    input wire logic rdata_valid, tx_fifo_empty, tsr_empty, bit_tick, tx_int_normal,
    input wire logic timeout_int_raw, tx_int, timeout_int_en, mcr_dtr, sir_mode, dtr_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] reg_q, reg_next, cnt_q, cnt_next;
    logic hit, wr_hit, busy, hd;
    assign hit = !cs_n && addr == 3'h2 && lcr_upper == 3'h4;
    assign wr_hit = hit && wr_strobe;
    assign busy = !tx_fifo_empty || !tsr_empty;
    assign hd = reg_q[2];
    // shadow register and bit times spent idle with driver on
    always_comb begin
        reg_next = wr_hit ? {wdata[7:1], 1'b0} : reg_q;
        cnt_next = (busy || thr_write || !dtr_out) ? 8'h00 : cnt_q + {7'h00, bit_tick};
    end
    always_ff @(posedge ref_clk) begin
        reg_q <= nrst ? reg_next : 8'h00;
        cnt_q <= nrst ? cnt_next : 8'h00;
    end
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!nrst);
    chk_sir_mode: assert property (wr_hit |-> ##2 sir_mode == $past(wdata[1], 2))
        else $error("sir_mode wrong");
    chk_dtr_pending: assert property (hd && busy |=> dtr_out)
        else $error("dtr_out low with data pending");
    chk_dtr_drop: assert property ($fell(dtr_out) && $past(hd) |->
        $past(!busy) && cnt_q >= {5'h00, reg_q[7:5]})
        else $error("dtr_out dropped early");
    chk_dtr_modem: assert property (!hd |=> dtr_out == $past(mcr_dtr))
        else $error("dtr_out not modem value");
    chk_timeout_gate: assert property (timeout_int_en |-> $past(timeout_int_raw && reg_q[4]))
        else $error("timeout not gated");
    chk_tx_hold: assert property (tx_int && $past(hd && !reg_q[3]) |->
        $past(tsr_empty) && !$past(tsr_empty, 2))
        else $error("tx_int not held off");
    chk_tx_normal: assert property ($past(!hd || reg_q[3]) |-> tx_int == $past(tx_int_normal))
        else $error("tx_int not normal");
    chk_read_back: assert property (hit && rd_strobe |=> rdata_valid && rdata == $past(reg_q))
        else $error("read data wrong");
    cover property (hit && rd_strobe);
    cover property ($fell(dtr_out) && hd);
    cover property (tx_int && hd && !reg_q[3]);
endmodule

// file: sim/test_afc_ctrl.sv
module test_afc_ctrl;
    timeunit 1ns;
    timeprecision 1ps;
    import afc_pkg::*;
    logic ref_clk = 1'b0, nrst = 1'b0, cs_n = 1'b1, wr_strobe = 1'b0, rd_strobe = 1'b0;
    logic thr_write = 1'b0, tx_fifo_empty = 1'b1, tsr_empty = 1'b1, tx_below_threshold = 1'b0;
    logic bit_tick = 1'b0, tx_active = 1'b0, tx_int_normal = 1'b0, timeout_int_raw = 1'b0;
    logic mcr_dtr = 1'b0, tx_line = 1'b1;
    logic [2:0] addr = 3'h0, lcr_upper = 3'h0;
    logic [7:0] wdata = 8'h00, rdata;
    logic [1:0] tick_cnt = 2'h0;
    logic rdata_valid, tx_int, timeout_int_en, rx_enable, sir_mode, dtr_out, bus_line;
    int num_errors = 0, total_checks = 0, cycles = 0;
    afc_ctrl afc_ctrl_i (.*);
    afc_xcvr_model afc_xcvr_model_i (.*);
    initial forever #5 ref_clk = ~ref_clk;
    always @(posedge ref_clk) begin
        tick_cnt <= tick_cnt + 2'h1;
        bit_tick <= &tick_cnt;
        cycles <= cycles + 1;
        if (cycles == 2000) begin
            num_errors = num_errors + 1;
            conclude();
        end
    end
    // ----------------------------------------
    // tasks
    // ----------------------------------------
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic acc(input logic wr, input logic [2:0] line_control_register, input logic [7:0] v);
        @(posedge ref_clk);
        cs_n <= 1'b0;
        addr <= 3'h2;
        lcr_upper <= line_control_register;
        wdata <= v;
        wr_strobe <= wr;
        rd_strobe <= !wr;
        @(posedge ref_clk);
        cs_n <= 1'b1;
        wr_strobe <= 1'b0;
        rd_strobe <= 1'b0;
    endtask
    task automatic wt(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    task automatic conclude();
        if (num_errors == 0 && total_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // ----------------------------------------
    // tests
    // ----------------------------------------
    initial begin
        repeat (6) @(posedge ref_clk);
        nrst <= 1'b1;
        wt(1);
        chk({6'h00, rx_enable, dtr_out}, 8'h02);
        acc(1'b1, 3'h3, 8'hFF);
        acc(1'b0, 3'h4, 8'h00);
        wt(1);
        chk(rdata, 8'h00);
        acc(1'b1, 3'h4, 8'h45);
        acc(1'b0, 3'h4, 8'h00);
        wt(1);
        chk(rdata, 8'h44);
        @(posedge ref_clk);
        tx_fifo_empty <= 1'b0;
        tsr_empty <= 1'b0;
        tx_active <= 1'b1;
        tx_line <= 1'b0;
        timeout_int_raw <= 1'b1;
        wt(3);
        chk({5'h00, dtr_out, rx_enable, bus_line}, 8'h04);
        chk({7'h00, timeout_int_en}, 8'h00);
        @(posedge ref_clk);
        tx_fifo_empty <= 1'b1;
        tsr_empty <= 1'b1;
        tx_active <= 1'b0;
        wt(3);
        chk({7'h00, dtr_out}, 8'h01);
        @(posedge ref_clk);
        thr_write <= 1'b1;
        @(posedge ref_clk);
        thr_write <= 1'b0;
        wt(3);
        chk({7'h00, dtr_out}, 8'h01);
        wt(20);
        chk({6'h00, dtr_out, bus_line}, 8'h01);
        @(posedge ref_clk);
        mcr_dtr <= 1'b1;
        acc(1'b1, 3'h4, 8'h10);
        wt(3);
        chk({5'h00, timeout_int_en, rx_enable, dtr_out}, 8'h07);
        acc(1'b1, 3'h4, 8'h02);
        @(posedge ref_clk);
        tx_active <= 1'b1;
        tx_int_normal <= 1'b1;
        wt(3);
        chk({6'h00, sir_mode, rx_enable}, 8'h02);
        acc(1'b1, 3'h4, 8'h0C);
        wt(3);
        chk({7'h00, tx_int}, 8'h01);
        acc(1'b1, 3'h4, 8'h04);
        wt(3);
        chk({7'h00, tx_int}, 8'h00);
        @(posedge ref_clk);
        tsr_empty <= 1'b0;
        @(posedge ref_clk);
        tsr_empty <= 1'b1;
        wt(1);
        chk({7'h00, tx_int}, 8'h01);
        wt(1);
        chk({7'h00, tx_int}, 8'h00);
        wt(2);
        conclude();
    end
endmodule
bind afc_ctrl afc_ctrl_sva afc_ctrl_sva_i (.*);
